// *** common/sea_defs.svh ***
`ifndef SEA_DEFS_SVH
`define SEA_DEFS_SVH

// ==========================================================================
// Command bytes and opcode fields
`define SEA_OPC_WR_ENABLE 8'h06
`define SEA_OPC_WRDI      8'h04
`define SEA_OPC_RDSR      8'h05
`define SEA_OPC_READ_LOW  3'h3
`define SEA_OPC_WRITE_LOW 3'h2
`define SEA_OPC_HIGH_BIT  3

// ==========================================================================
// Status byte layout
`define SEA_ST_BUSY       0
`define SEA_ST_WR_LATCH   1
`define SEA_ST_BL_LSB     2
`define SEA_ST_WD_LSB     4

// ==========================================================================
// Timing
`define SEA_CLK_KHZ       25000
`define SEA_T_WC_MS       10
`define SEA_T_PURST_MS    200
`define SEA_WC_CYCLES     (`SEA_T_WC_MS * `SEA_CLK_KHZ)
`define SEA_PURST_CYCLES  (`SEA_T_PURST_MS * `SEA_CLK_KHZ)

`endif

// *** common/sea_pkg.sv ***
package sea_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_OPC   = 3'h1,
    ST_ADDR  = 3'h2,
    ST_RDATA = 3'h3,
    ST_WDATA = 3'h4,
    ST_STAT  = 3'h5,
    ST_SKIP  = 3'h6
  } sea_state_t;
  typedef logic [7:0] sea_byte_t;
endpackage : sea_pkg

// *** hw/sea_buf2.sv ***
`timescale 1ns/10ps
module sea_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         flush,
  // Filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic         wr_idx, rd_idx, next_wr_idx, next_rd_idx;
  logic [1:0]   count, next_count;
  logic         push, pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_idx];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_count  = count;
    if (flush) begin
      next_wr_idx = 1'b0;
      next_rd_idx = 1'b0;
      next_count  = 2'h0;
    end else begin
      if (push) begin
        next_mem[wr_idx] = in_data;
        next_wr_idx      = ~wr_idx;
      end
      if (pop) begin
        next_rd_idx = ~rd_idx;
      end
      next_count = count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count  <= 2'h0;
    end else begin
      mem    <= next_mem;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count  <= next_count;
    end
  end
endmodule : sea_buf2

// *** hw/sea_core.sv ***
// Operation
// RULE1: host sends read opcode then address byte.
// RULE2: read opcode bit 3 is high address bit.
// RULE3: selected byte shifted out, MSB first.
// RULE4: address advances after every byte read.
// RULE5: read address wraps from top to zero.
// RULE6: chip select high ends read, releases output.
// RULE7: write needs latch set in earlier frame.
// RULE8: host sends write opcode, address, then data.
// RULE9: write opcode bit 3 is high address bit.
// RULE10: write frame holds at least sixteen clocks; the code needs twenty-four (one data byte).
// RULE11: up to sixteen bytes within one page.
// RULE12: write pointer wraps inside the page.
// RULE13: write starts only on byte-boundary deselect.
// RULE14: status shows write in progress while busy.
// RULE15: command accepted only after chip-select fall.
// RULE16: serial output undriven from power-up.
// RULE17: power-up clears enable latch and flag.
// RULE18: reset output held for power-up time-out.
// RULE19: protected blocks readable but never programmed.
// RULE20: protect pin low blocks write start.
// RULE21: read low bits 011, write 010.
// RULE22: enable command is byte 06, alone.
// RULE23: completed write clears the enable latch.
// RULE24: sample on rising, shift out on falling.
// RULE25: refused write changes nothing at all.
// RULE26: busy device ignores array commands, allows status.
`timescale 1ns/10ps
`include "sea_defs.svh"
module sea_core #(
  parameter int unsigned WC_CYCLES    = `SEA_WC_CYCLES,
  parameter int unsigned PURST_CYCLES = `SEA_PURST_CYCLES
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Serial link pins
  input  wire logic              sck,
  input  wire logic              cs_b,
  input  wire logic              si,
  input  wire logic              wp_b,
  output logic                   so_o,
  output logic                   so_oe,
  // Nonvolatile settings
  input  wire logic [1:0]        block_prot,
  input  wire logic [1:0]        wd_bits,
  // State
  output logic                   write_in_progress,
  output logic                   write_enable_latch,
  output logic                   sys_reset_out
);
  import sea_pkg::*;

  // ========================================================================
  // Input synchronisers
  logic [3:0] sync1, sync2;
  logic       sck_d, cs_d;
  logic       sck_s, cs_s, si_s, wp_s;
  logic       sck_rise, sck_fall, cs_rise, cs_fall;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // The clock bit resets low like its edge detector, so no false edge follows reset.
      sync1 <= 4'hA;
      sync2 <= 4'hA;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sync1 <= {wp_b, si, cs_b, sck};
      sync2 <= sync1;
      sck_d <= sync2[0];
      cs_d  <= sync2[1];
    end
  end

  assign sck_s    = sync2[0];
  assign cs_s     = sync2[1];
  assign si_s     = sync2[2];
  assign wp_s     = sync2[3];
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign cs_rise  = cs_s & ~cs_d;
  assign cs_fall  = ~cs_s & cs_d;

  // ========================================================================
  // Array storage
  // The array has no reset: it models nonvolatile cells.
  sea_byte_t  mem [512];
  sea_byte_t  pbuf [16], next_pbuf [16];
  logic       start_wr;

  // ========================================================================
  // Command state
  sea_state_t state, next_state;
  logic [2:0] bitcnt, next_bitcnt, obit, next_obit;
  sea_byte_t  shin, next_shin, oshift, next_oshift;
  sea_byte_t  byte_in, stat_byte, load_byte;
  logic       armed, next_armed, hi_bit, next_hi_bit, op_wr, next_op_wr;
  logic [8:0] raddr, next_raddr;
  logic [4:0] page, next_page;
  logic [3:0] wptr, next_wptr;
  logic [15:0] mask, next_mask;
  logic       wlatch, next_wlatch, busy, next_busy;
  logic       so_q, next_so_q, oe_q, next_oe_q;
  logic [31:0] wc_cnt, next_wc_cnt, por_cnt, next_por_cnt;
  logic       por_act, next_por_act;
  logic       prot_hit, flush, fetch_ready, pop, buf_valid;
  sea_byte_t  buf_data;

  assign byte_in   = {shin[6:0], si_s};
  assign stat_byte = {2'b00, wd_bits, block_prot, wlatch, busy}; // RULE14

  // A page is protected as a whole, since every protected range is page aligned.
  always_comb begin
    unique case (block_prot) // RULE19
      2'h0: prot_hit = 1'b0;
      2'h1: prot_hit = (page[4:3] == 2'h3);
      2'h2: prot_hit = page[4];
      2'h3: prot_hit = 1'b1;
    endcase
  end

  // ========================================================================
  // Read prefetch buffer
  // The prefetch keeps the next byte ready well ahead of the falling edge that needs it.
  assign pop = (state == ST_RDATA) && sck_fall && (obit == 3'h0);

  sea_buf2 #(.W(8)) u_buf (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .flush     (flush),
    .in_valid  (state == ST_RDATA),
    .in_data   (mem[raddr]),
    .in_ready  (fetch_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (pop)
  );

  // ========================================================================
  // Next-state logic
  always_comb begin
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_obit    = obit;
    next_shin    = shin;
    next_oshift  = oshift;
    next_armed   = armed | cs_s;
    next_hi_bit  = hi_bit;
    next_op_wr   = op_wr;
    next_raddr   = raddr;
    next_page    = page;
    next_wptr    = wptr;
    next_mask    = mask;
    next_pbuf    = pbuf;
    next_wlatch  = wlatch;
    next_busy    = busy;
    next_so_q    = so_q;
    next_oe_q    = oe_q;
    next_wc_cnt  = wc_cnt;
    next_por_cnt = por_cnt;
    next_por_act = por_act;
    start_wr     = 1'b0;
    flush        = 1'b0;
    load_byte    = 8'h00;

    if (cs_rise) begin
      // Deselect ends any frame and releases the output.
      next_state = ST_IDLE; // RULE6
      next_oe_q  = 1'b0; // RULE6
      flush      = 1'b1;
      if (state == ST_WDATA && bitcnt == 3'h0 && mask != 16'h0000 // RULE13
          && wp_s && !prot_hit && !busy && wlatch) begin // RULE20 RULE19 RULE25
        start_wr    = 1'b1;
        next_busy   = 1'b1; // RULE14
        next_wc_cnt = WC_CYCLES - 32'h1;
      end
    end else if (cs_fall && armed) begin
      next_state  = ST_OPC; // RULE15
      next_bitcnt = 3'h0;
      next_obit   = 3'h0;
    end else if (state != ST_IDLE) begin
      if (sck_rise) begin
        next_shin   = byte_in; // RULE24
        next_bitcnt = bitcnt + 3'h1;
      end
      if (sck_rise && bitcnt == 3'h7) begin
        unique case (state)
          ST_OPC: begin
            next_state  = ST_SKIP;
            next_hi_bit = byte_in[`SEA_OPC_HIGH_BIT]; // RULE2 RULE9
            if (byte_in == `SEA_OPC_RDSR) begin
              next_state = ST_STAT; // RULE26
            end else if (!busy) begin // RULE26
              if (byte_in == `SEA_OPC_WR_ENABLE) begin
                next_wlatch = 1'b1; // RULE22
              end else if (byte_in == `SEA_OPC_WRDI) begin
                next_wlatch = 1'b0;
              end else if (byte_in[7:4] == 4'h0 && byte_in[2:0] == `SEA_OPC_READ_LOW) begin // RULE21
                next_state = ST_ADDR; // RULE1
                next_op_wr = 1'b0;
              end else if (byte_in[7:4] == 4'h0 && byte_in[2:0] == `SEA_OPC_WRITE_LOW
                           && wlatch) begin // RULE7 RULE21
                next_state = ST_ADDR; // RULE8
                next_op_wr = 1'b1;
              end
            end
          end
          ST_ADDR: begin
            if (op_wr) begin
              next_state = ST_WDATA;
              next_page  = {hi_bit, byte_in[7:4]};
              next_wptr  = byte_in[3:0];
              next_mask  = 16'h0000;
            end else begin
              next_state = ST_RDATA;
              next_raddr = {hi_bit, byte_in};
            end
          end
          ST_WDATA: begin
            next_pbuf[wptr] = byte_in; // RULE11
            next_mask[wptr] = 1'b1;
            next_wptr       = wptr + 4'h1; // RULE12
          end
          default: begin
          end
        endcase
      end
      if (sck_fall && (state == ST_RDATA || state == ST_STAT)) begin
        next_obit = obit + 3'h1;
        if (obit == 3'h0) begin
          if (state == ST_STAT) begin
            load_byte = stat_byte;
          end else if (buf_valid) begin
            load_byte = buf_data; // RULE3
          end
          next_so_q   = load_byte[7]; // RULE24
          next_oshift = {load_byte[6:0], 1'b0};
          next_oe_q   = 1'b1;
        end else begin
          next_so_q   = oshift[7];
          next_oshift = {oshift[6:0], 1'b0};
        end
      end
    end

    if (state == ST_RDATA && fetch_ready && !cs_rise) begin
      next_raddr = raddr + 9'h001; // RULE4 RULE5
    end

    if (busy) begin
      if (wc_cnt == 32'h0) begin
        next_busy = 1'b0;
        next_wlatch = 1'b0; // RULE23
      end else begin
        next_wc_cnt = wc_cnt - 32'h1;
      end
    end

    // The protect pin clears the latch, and wins over a same-cycle enable.
    if (!wp_s) begin
      next_wlatch = 1'b0; // RULE20
    end

    if (por_act) begin
      if (por_cnt == PURST_CYCLES - 32'h1) begin
        next_por_act = 1'b0; // RULE18
      end else begin
        next_por_cnt = por_cnt + 32'h1;
      end
    end
  end

  // ========================================================================
  // State registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= ST_IDLE; // RULE15
      bitcnt  <= 3'h0;
      obit    <= 3'h0;
      shin    <= 8'h00;
      oshift  <= 8'h00;
      armed   <= 1'b0;
      hi_bit  <= 1'b0;
      op_wr   <= 1'b0;
      raddr   <= 9'h000;
      page    <= 5'h00;
      wptr    <= 4'h0;
      mask    <= 16'h0000;
      wlatch  <= 1'b0; // RULE17
      busy    <= 1'b0; // RULE17
      so_q    <= 1'b0;
      oe_q    <= 1'b0; // RULE16
      wc_cnt  <= 32'h0;
      por_cnt <= 32'h0;
      por_act <= 1'b1; // RULE18
    end else begin
      state   <= next_state;
      bitcnt  <= next_bitcnt;
      obit    <= next_obit;
      shin    <= next_shin;
      oshift  <= next_oshift;
      armed   <= next_armed;
      hi_bit  <= next_hi_bit;
      op_wr   <= next_op_wr;
      raddr   <= next_raddr;
      page    <= next_page;
      wptr    <= next_wptr;
      mask    <= next_mask;
      wlatch  <= next_wlatch;
      busy    <= next_busy;
      so_q    <= next_so_q;
      oe_q    <= next_oe_q;
      wc_cnt  <= next_wc_cnt;
      por_cnt <= next_por_cnt;
      por_act <= next_por_act;
    end
  end

  // Page data is held until the next write frame, so it needs no reset.
  always_ff @(posedge mclk) begin
    pbuf <= next_pbuf;
  end

  // Cells change on the start edge; reads are refused until the cycle ends.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      if (start_wr && mask[i]) begin
        mem[{page, i[3:0]}] <= pbuf[i]; // RULE13 RULE25
      end
    end
  end

  assign so_o               = so_q;
  assign so_oe              = oe_q;
  assign write_in_progress  = busy;
  assign write_enable_latch = wlatch;
  assign sys_reset_out      = por_act;
endmodule : sea_core

// *** tb/sea_core_asserts.sv ***
`timescale 1ns/10ps
module sea_core_asserts #(
  parameter int unsigned WC_CYCLES    = 50,
  parameter int unsigned PURST_CYCLES = 20
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // Link pins
  input wire logic       sck,
  input wire logic       cs_b,
  input wire logic       si,
  input wire logic       wp_b,
  input wire logic       so_o,
  input wire logic       so_oe,
  // Settings
  input wire logic [1:0] block_prot,
  input wire logic [1:0] wd_bits,
  // State
  input wire logic       write_in_progress,
  input wire logic       write_enable_latch,
  input wire logic       sys_reset_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Counters
  int unsigned up_cnt;
  int unsigned next_up_cnt;
  int unsigned busy_cnt;
  int unsigned next_busy_cnt;
  // The up counter saturates so that it cannot wrap in a long run.
  always_comb begin
    next_up_cnt   = (up_cnt < PURST_CYCLES + 4) ? up_cnt + 1 : up_cnt;
    next_busy_cnt = write_in_progress ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt   <= 0;
      busy_cnt <= 0;
    end else begin
      up_cnt   <= next_up_cnt;
      busy_cnt <= next_busy_cnt;
    end
  end
  sequence s_wr_start;
    $rose(write_in_progress);
  endsequence
  sequence s_wr_end;
    $fell(write_in_progress);
  endsequence
  a_reset_quiet:
    assert property ($rose(rst_b) |-> !so_oe && !write_enable_latch && !write_in_progress && sys_reset_out)
    else $error("outputs not quiet after reset");
  a_purst_hold:
    assert property (up_cnt < PURST_CYCLES |-> sys_reset_out) else $error("reset out dropped early");
  a_purst_end:
    assert property (up_cnt >= PURST_CYCLES + 2 |-> !sys_reset_out) else $error("reset out held too long");
  a_oe_deselect:
    assert property (cs_b [*5] |-> !so_oe) else $error("output driven while deselected");
  a_so_on_fall:
    assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sck && !$past(sck, 2))
    else $error("output changed outside clock low");
  a_wr_needs_wel:
    assert property (s_wr_start |-> write_enable_latch) else $error("write without latch");
  a_wr_needs_wp:
    assert property (s_wr_start |-> wp_b) else $error("write while protect pin low");
  a_wr_deselect:
    assert property (s_wr_start |-> cs_b && $past(cs_b)) else $error("write started while selected");
  a_wr_not_all:
    assert property (s_wr_start |-> block_prot != 2'h3) else $error("write with whole array protected");
  a_wr_clears_wel:
    assert property (s_wr_end |-> !write_enable_latch) else $error("latch kept after write");
  a_wr_length:
    assert property (s_wr_end |-> busy_cnt >= WC_CYCLES && busy_cnt <= WC_CYCLES + 1)
    else $error("busy time wrong");
endmodule : sea_core_asserts

// *** tb/sea_host.sv ***
`timescale 1ns/10ps
module sea_host (
  // Clock
  input wire logic mclk,
  // Link pins
  output logic     sck,
  output logic     cs_b,
  output logic     si,
  input wire logic so_o,
  input wire logic so_oe
);
  logic [31:0] rx;
  logic        oe_seen;
  logic        so_last;
  // A released output toggles so that stale data cannot pass for a match.
  wire logic   so_w = so_oe ? so_o : ~so_last;
  initial begin
    sck     = 1'b0;
    cs_b    = 1'b1;
    si      = 1'b0;
    rx      = '0;
    oe_seen = 1'b0;
    so_last = 1'b0;
  end
  always @(posedge mclk) begin
    so_last <= so_w;
    if (so_oe) oe_seen <= 1'b1;
  end
  // ==========================================================
  // One frame, mode 0, 8 mclk per bit
  task automatic frame(input logic [31:0] tx, input int nb, input int xb);
    oe_seen = 1'b0;
    cs_b <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < nb * 8 + xb; i++) begin
      si <= tx[31-i];
      repeat (4) @(posedge mclk);
      sck <= 1'b1;
      rx[31-i] = so_w;
      repeat (4) @(posedge mclk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    cs_b <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask : frame
endmodule : sea_host

// *** tb/tb_sea_core.sv ***
`timescale 1ns/10ps
module tb_sea_core;
  localparam int unsigned WC = 600;
  localparam int unsigned PR = 20;
  logic       mclk;
  logic       rst_b;
  logic       wp_b;
  logic [1:0] block_prot;
  logic [1:0] wd_bits;
  wire logic  sck, cs_b, si, so_o, so_oe, busy_o, latch_o, sys_rst;
  int         err_total;
  int         n_compared;

  always #20 mclk = ~mclk;

  sea_core #(.WC_CYCLES(WC), .PURST_CYCLES(PR)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .wp_b(wp_b), .so_o(so_o),
    .so_oe(so_oe), .block_prot(block_prot), .wd_bits(wd_bits), .write_in_progress(busy_o),
    .write_enable_latch(latch_o), .sys_reset_out(sys_rst)
  );
  sea_host i_host (.mclk(mclk), .sck(sck), .cs_b(cs_b), .si(si), .so_o(so_o), .so_oe(so_oe));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_en();
    i_host.frame(32'h0600_0000, 1, 0);
  endtask : wr_en
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    mclk       = 1'b0;
    rst_b      = 1'b0;
    wp_b       = 1'b1;
    block_prot = 2'h0;
    wd_bits    = 2'h2;
    err_total  = 0;
    n_compared = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(8'({so_oe, latch_o, busy_o, sys_rst}), 8'h01);
    repeat (PR + 4) @(posedge mclk);
    chk(8'(sys_rst), 8'h00);
    done("power_up");
    i_host.frame(32'h0210_AA00, 3, 0);
    chk(8'({latch_o, busy_o}), 8'h00);
    done("locked");
    wr_en();
    chk(8'(latch_o), 8'h01);
    i_host.frame(32'h0AFF_5566, 4, 0);
    chk(8'(busy_o), 8'h01);
    repeat (WC + 10) @(posedge mclk);
    chk(8'({latch_o, busy_o}), 8'h00);
    wr_en();
    i_host.frame(32'h0200_7700, 3, 0);
    repeat (WC + 10) @(posedge mclk);
    i_host.frame(32'h0BFF_0000, 4, 0);
    chk(i_host.rx[15:8], 8'h55);
    chk(i_host.rx[7:0], 8'h77);
    i_host.frame(32'h0BF0_0000, 3, 0);
    chk(i_host.rx[15:8], 8'h66);
    done("write_read");
    wr_en();
    i_host.frame(32'h0200_8800, 3, 3);
    chk(8'({latch_o, busy_o}), 8'h02);
    done("cancel");
    wp_b <= 1'b0;
    wr_en();
    i_host.frame(32'h0200_9900, 3, 0);
    chk(8'({latch_o, busy_o}), 8'h00);
    wp_b       <= 1'b1;
    block_prot <= 2'h1;
    done("protect_pin");
    wr_en();
    i_host.frame(32'h0AFF_1200, 3, 0);
    chk(8'({latch_o, busy_o}), 8'h02);
    i_host.frame(32'h0BFF_0000, 3, 0);
    chk(i_host.rx[15:8], 8'h55);
    done("block_protect");
    i_host.frame(32'h0200_AB00, 3, 0);
    i_host.frame(32'h0500_0000, 2, 0);
    chk(i_host.rx[23:16], 8'h27);
    i_host.frame(32'h0300_0000, 3, 0);
    chk(8'(i_host.oe_seen), 8'h00);
    repeat (WC) @(posedge mclk);
    i_host.frame(32'h0300_0000, 3, 0);
    chk(i_host.rx[15:8], 8'hAB);
    done("busy");
    summarize();
  end
endmodule : tb_sea_core

bind sea_core sea_core_asserts #(.WC_CYCLES(WC_CYCLES), .PURST_CYCLES(PURST_CYCLES)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .wp_b(wp_b), .so_o(so_o),
  .so_oe(so_oe), .block_prot(block_prot), .wd_bits(wd_bits), .write_in_progress(write_in_progress),
  .write_enable_latch(write_enable_latch), .sys_reset_out(sys_reset_out)
);
